// ---- reset_supervisor.sv ----
// reset supervisor timing: undervoltage hold-off and manual reset pulses
// Functional notes
// R01: undervoltage on either monitor asserts reset immediately
// R02: hold reset for recovery timeout after recovery
// R03: single long press must hold full setup
// R04: valid manual request gives one-shot pulse
// R05: manual pulse within 140 to 280 ms
// R06: hold setup period is build option
// R07: dual variant needs both inputs low together
// R08: one pulse per press; release required
// R09: long-press release is debounced internally
// R10: instant input high starts pulse immediately
// R11: instant input rejects short glitches
// R12: instant request asserts reset within 200 ns; the code needs about 53 cycles (530 ns) via the 50-cycle filter
// R13: operator holds both inputs low together
// R14: new instant edge restarts pulse timer
// R15: instant input falling edge debounced 210 ms
// R16: all intervals are counters on one clock
// R17: reset is OR of both sources
`timescale 1ns/10ps
module reset_supervisor #(
	parameter logic [1:0] VARIANT = reset_supervisor_pkg::VARIANT_SINGLE,
	parameter logic [1:0] HOLD_OPTION = reset_supervisor_pkg::HOLD_OPT_L,
	parameter int SUPPLY_RECOVERY_CYCLES = reset_supervisor_pkg::SUPPLY_RECOVERY_CYCLES,
	parameter int MANUAL_PULSE_CYCLES = reset_supervisor_pkg::MANUAL_PULSE_CYCLES,
	parameter int CYCLES_PER_10MS = reset_supervisor_pkg::CYCLES_PER_10MS,
	parameter int RELEASE_DEBOUNCE_CYCLES = reset_supervisor_pkg::RELEASE_DEBOUNCE_CYCLES,
	parameter int INSTANT_FALL_CYCLES = reset_supervisor_pkg::INSTANT_FALL_CYCLES
) (
	// clock and synchronous reset
	input wire logic REF_CLK,
	input wire logic RST,
	// comparator results, high while the level is below its trip level
	input wire logic SUPPLY_LOW,
	input wire logic AUX_LOW,
	// manual inputs
	input wire logic LONG_PRESS_IN_A_N,
	input wire logic LONG_PRESS_IN_B_OR_INSTANT_IN,
	// reset to processor
	output logic RESET_OUT_N
);
	localparam int HOLD_10MS = (HOLD_OPTION == reset_supervisor_pkg::HOLD_OPT_K) ?
		reset_supervisor_pkg::HOLD_10MS_K : (HOLD_OPTION == reset_supervisor_pkg::HOLD_OPT_L) ?
		reset_supervisor_pkg::HOLD_10MS_L : (HOLD_OPTION == reset_supervisor_pkg::HOLD_OPT_S) ?
		reset_supervisor_pkg::HOLD_10MS_S : reset_supervisor_pkg::HOLD_10MS_T; // R06
	// 32-bit timers hold every count the package can give
	localparam int TW = 32;
	// refuse builds that the counters cannot serve
	if (VARIANT > reset_supervisor_pkg::VARIANT_INSTANT)
	begin : bad_variant
		$error("unsupported variant");
	end
	if (SUPPLY_RECOVERY_CYCLES < 1 || MANUAL_PULSE_CYCLES < 1 || CYCLES_PER_10MS < 1)
	begin : bad_timing
		$error("timing counts must be at least one");
	end
	if (RELEASE_DEBOUNCE_CYCLES < 1 || INSTANT_FALL_CYCLES < 1)
	begin : bad_debounce
		$error("debounce counts must be at least one");
	end
	if (HOLD_10MS > 16'hFFFF)
	begin : bad_hold
		$error("hold setup does not fit the tick counter");
	end

	// every register of the block, filled by one always_comb
	typedef struct packed {
		logic [1:0] sync_a;
		logic [1:0] sync_b;
		logic [1:0] sync_sup;
		logic [1:0] sync_aux;
		logic [TW-1:0] recovery_count;
		logic uv_active;
		logic [TW-1:0] tick_count;
		logic [15:0] hold_count;
		logic armed;
		logic [TW-1:0] pulse_count;
		logic pulse_active;
		logic instant_prev;
		logic reset_n;
	} state_t;
	state_t s;
	state_t next_s;

	// filtered press levels and one-cycle request strobes
	logic press_a;
	logic press_b;
	logic instant_level;
	logic pressed;
	logic start_pulse;
	logic instant_edge;

	// release debounce: press is taken at once, release only after a stable high
	level_filter #(
		.RISE_CYCLES(1),
		.FALL_CYCLES(RELEASE_DEBOUNCE_CYCLES)
	) filt_a (
		.clk(REF_CLK),
		.rst(RST),
		.level_in(~s.sync_a[1]),
		.level_out(press_a)
	); // R09
	level_filter #(
		.RISE_CYCLES(1),
		.FALL_CYCLES(RELEASE_DEBOUNCE_CYCLES)
	) filt_b (
		.clk(REF_CLK),
		.rst(RST),
		.level_in(~s.sync_b[1]),
		.level_out(press_b)
	); // R09
	// instant input: short glitch filter up, long debounce down
	level_filter #(
		.RISE_CYCLES(reset_supervisor_pkg::INSTANT_FILTER_CYCLES),
		.FALL_CYCLES(INSTANT_FALL_CYCLES)
	) filt_i (
		.clk(REF_CLK),
		.rst(RST),
		.level_in(s.sync_b[1]),
		.level_out(instant_level)
	); // R11 R15

	// one-cycle strobe on a filtered rise; prev resets low like the idle input
	assign instant_edge = (VARIANT == reset_supervisor_pkg::VARIANT_INSTANT) && instant_level &&
		!s.instant_prev;

	// qualifying press condition for the build variant
	always_comb
	begin
		case (VARIANT)
			reset_supervisor_pkg::VARIANT_SINGLE: pressed = press_a; // R03
			reset_supervisor_pkg::VARIANT_DUAL: pressed = press_a & press_b; // R07 R13
			reset_supervisor_pkg::VARIANT_INSTANT: pressed = press_a;
			default: pressed = 1'b0;
		endcase
	end

	always_comb
	begin
		next_s = s;
		start_pulse = 1'b0;
		// two-stage synchronisers, stage 1 read only by stage 2
		next_s.sync_a = {s.sync_a[0], LONG_PRESS_IN_A_N};
		next_s.sync_b = {s.sync_b[0], LONG_PRESS_IN_B_OR_INSTANT_IN};
		next_s.sync_sup = {s.sync_sup[0], SUPPLY_LOW};
		next_s.sync_aux = {s.sync_aux[0], AUX_LOW};

		// undervoltage: recovery timer restarts while any monitor is low
		if (s.sync_sup[1] || s.sync_aux[1])
		begin
			next_s.uv_active = 1'b1; // R01
			next_s.recovery_count = '0;
		end
		else if (s.uv_active)
		begin
			if (int'(s.recovery_count) + 1 >= SUPPLY_RECOVERY_CYCLES)
				next_s.uv_active = 1'b0; // R02
			else
				next_s.recovery_count = s.recovery_count + TW'(1);
		end

		// hold setup timing in 10 ms ticks; any release clears it
		if (!pressed)
		begin
			next_s.tick_count = '0;
			next_s.hold_count = '0;
			next_s.armed = 1'b1; // R08
		end
		else if (s.armed)
		begin
			if (int'(s.tick_count) + 1 >= CYCLES_PER_10MS)
			begin
				next_s.tick_count = '0;
				if (int'(s.hold_count) + 1 >= HOLD_10MS)
				begin
					next_s.armed = 1'b0; // R08
					start_pulse = 1'b1; // R03 R07
				end
				else
					next_s.hold_count = s.hold_count + 16'h0001;
			end
			else
				next_s.tick_count = s.tick_count + TW'(1); // R16
		end

		// instant input rising edge after the filter
		next_s.instant_prev = instant_level;
		if (instant_edge)
			start_pulse = 1'b1; // R10 R14

		// manual one-shot pulse, restarted by any new request
		if (start_pulse)
		begin
			next_s.pulse_active = 1'b1; // R04
			next_s.pulse_count = '0; // R14
		end
		else if (s.pulse_active)
		begin
			if (int'(s.pulse_count) + 1 >= MANUAL_PULSE_CYCLES)
				next_s.pulse_active = 1'b0; // R05
			else
				next_s.pulse_count = s.pulse_count + TW'(1);
		end

		// output from a flop; low while either source asks
		next_s.reset_n = ~(next_s.uv_active | next_s.pulse_active); // R17 R12
	end

	// power-on state: reset asserted until recovery timeout runs out
	always_ff @(posedge REF_CLK)
	begin
		if (RST)
		begin
			s <= '0;
			s.sync_a <= 2'h3;
			s.sync_b <= (VARIANT == reset_supervisor_pkg::VARIANT_DUAL) ? 2'h3 : 2'h0;
			s.uv_active <= 1'b1; // R17
		end
		else
			s <= next_s;
	end

	// registered, so no decode glitch reaches the processor reset
	assign RESET_OUT_N = s.reset_n;
endmodule : reset_supervisor

// ---- reset_supervisor_pkg.sv ----
// constants shared by the reset supervisor timing logic
package reset_supervisor_pkg;
	// clock rate in kHz, 100 MHz reference
	localparam int CLK_KHZ = 100000;
	// supply and auxiliary recovery timeout, ms
	localparam int SUPPLY_RECOVERY_MS = 210;
	localparam int SUPPLY_RECOVERY_CYCLES = SUPPLY_RECOVERY_MS * CLK_KHZ;
	// manual pulse timeout, ms (typical of 140..280 window)
	localparam int MANUAL_PULSE_MS = 210;
	localparam int MANUAL_PULSE_CYCLES = MANUAL_PULSE_MS * CLK_KHZ;
	// hold setup period options, in units of 10 ms
	localparam int HOLD_10MS_K = 1008;
	localparam int HOLD_10MS_L = 672;
	localparam int HOLD_10MS_S = 336;
	localparam int HOLD_10MS_T = 168;
	localparam int CYCLES_PER_10MS = 10 * CLK_KHZ;
	// release debounce of long-press inputs, ms
	localparam int RELEASE_DEBOUNCE_MS = 20;
	localparam int RELEASE_DEBOUNCE_CYCLES = RELEASE_DEBOUNCE_MS * CLK_KHZ;
	// instant input glitch filter, ns; rejects 100 ns, accepts 1 us
	localparam int INSTANT_FILTER_NS = 500;
	localparam int INSTANT_FILTER_CYCLES = INSTANT_FILTER_NS / 10;
	// instant input falling-edge debounce, ms
	localparam int INSTANT_FALL_MS = 210;
	localparam int INSTANT_FALL_CYCLES = INSTANT_FALL_MS * CLK_KHZ;
	// variant codes
	localparam logic [1:0] VARIANT_SINGLE = 2'h0;
	localparam logic [1:0] VARIANT_DUAL = 2'h1;
	localparam logic [1:0] VARIANT_INSTANT = 2'h2;
	// hold setup option codes
	localparam logic [1:0] HOLD_OPT_K = 2'h0;
	localparam logic [1:0] HOLD_OPT_L = 2'h1;
	localparam logic [1:0] HOLD_OPT_S = 2'h2;
	localparam logic [1:0] HOLD_OPT_T = 2'h3;
endpackage : reset_supervisor_pkg

// ---- level_filter.sv ----
// level filter: output follows input only after it has held a new level long enough
`timescale 1ns/10ps
module level_filter #(
	parameter int RISE_CYCLES = 1,
	parameter int FALL_CYCLES = 1
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// filtered level
	input wire logic level_in,
	output logic level_out
);
	localparam int MAXC = (RISE_CYCLES > FALL_CYCLES) ? RISE_CYCLES : FALL_CYCLES;
	localparam int CW = $clog2(MAXC + 1);
	// refuse counts that the filter cannot serve
	if (RISE_CYCLES < 1 || FALL_CYCLES < 1)
	begin : bad_counts
		$error("level_filter counts must be at least one");
	end
	typedef struct packed {
		logic out;
		logic [CW-1:0] count;
	} state_t;
	state_t s;
	state_t next_s;
	// count while the input differs from the output, flip at the target
	always_comb
	begin
		next_s = s;
		if (level_in == s.out)
			next_s.count = '0;
		else if (int'(s.count) + 1 >= (level_in ? RISE_CYCLES : FALL_CYCLES))
		begin
			next_s.out = level_in;
			next_s.count = '0;
		end
		else
			next_s.count = s.count + CW'(1);
	end
	always_ff @(posedge clk)
	begin
		if (rst)
			s <= '0;
		else
			s <= next_s;
	end
	assign level_out = s.out;
endmodule : level_filter

// ---- reset_supervisor_chk.sv ----
// port assertions for the reset supervisor
`timescale 1ns/10ps
module reset_supervisor_chk #(
	parameter logic [1:0] VARIANT = 2'h0,
	parameter logic [1:0] HOLD_OPTION = 2'h1,
	parameter int SUPPLY_RECOVERY_CYCLES = 1,
	parameter int MANUAL_PULSE_CYCLES = 1,
	parameter int CYCLES_PER_10MS = 1,
	parameter int INSTANT_FALL_CYCLES = 1
) (
	// clock and reset
	input wire logic REF_CLK,
	input wire logic RST,
	// watched pins
	input wire logic SUPPLY_LOW,
	input wire logic AUX_LOW,
	input wire logic LONG_PRESS_IN_A_N,
	input wire logic LONG_PRESS_IN_B_OR_INSTANT_IN,
	input wire logic RESET_OUT_N
);
	localparam int HOLD = CYCLES_PER_10MS * (HOLD_OPTION == 2'h0 ? 1008 :
		HOLD_OPTION == 2'h1 ? 672 : HOLD_OPTION == 2'h2 ? 336 : 168);
	localparam int P_MIN = MANUAL_PULSE_CYCLES * 2 / 3;
	localparam int Q_END = SUPPLY_RECOVERY_CYCLES + 8;
	localparam int M_END = MANUAL_PULSE_CYCLES + 64;
	int quiet, low_len, a_low, b_hi, b_lo, since;
	logic armed;
	// run lengths; since counts from the last thing allowed to start a pulse
	always_ff @(posedge REF_CLK)
	begin
		quiet <= (RST || SUPPLY_LOW || AUX_LOW) ? 0 : quiet + 1;
		low_len <= RESET_OUT_N ? 0 : low_len + 1;
		a_low <= (RST || LONG_PRESS_IN_A_N) ? 0 : a_low + 1;
		b_hi <= (RST || !LONG_PRESS_IN_B_OR_INSTANT_IN) ? 0 : b_hi + 1;
		b_lo <= LONG_PRESS_IN_B_OR_INSTANT_IN ? 0 : b_lo + 1;
		since <= (quiet == 0 || a_low == HOLD || b_hi == 10) ? 0 : since + 1;
		// a new instant edge only counts after a settled low
		armed <= !RST && (b_lo > INSTANT_FALL_CYCLES + 8 || (armed && b_hi != 60));
	end
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (RST);
	AST_UV_ASSERT: assert property ((SUPPLY_LOW || AUX_LOW) |-> ##4 !RESET_OUT_N)
		else $error("reset high in undervoltage");
	AST_UV_RECOVER: assert property ($rose(RESET_OUT_N) |-> quiet >= Q_END - 9)
		else $error("reset released early");
	AST_PULSE_MIN: assert property ($rose(RESET_OUT_N) |-> low_len >= P_MIN)
		else $error("reset pulse too short");
	AST_PULSE_HOLD: assert property ($fell(RESET_OUT_N) |=> !RESET_OUT_N [*8])
		else $error("reset pulse broken");
	AST_FALL_CAUSE: assert property ($fell(RESET_OUT_N) |-> since < 64)
		else $error("reset without cause");
	AST_INSTANT_FAST: assert property (VARIANT == 2'h2 && armed && b_hi == 60 |-> !RESET_OUT_N)
		else $error("instant request slow");
	AST_RELEASE: assert property (quiet > Q_END && since > M_END |-> RESET_OUT_N)
		else $error("reset stuck low");
	AST_RST_LOW: assert property (disable iff (1'b0) RST |=> !RESET_OUT_N)
		else $error("reset high after init");
endmodule : reset_supervisor_chk
bind reset_supervisor reset_supervisor_chk #(.VARIANT(VARIANT), .HOLD_OPTION(HOLD_OPTION),
	.SUPPLY_RECOVERY_CYCLES(SUPPLY_RECOVERY_CYCLES), .MANUAL_PULSE_CYCLES(MANUAL_PULSE_CYCLES),
	.CYCLES_PER_10MS(CYCLES_PER_10MS), .INSTANT_FALL_CYCLES(INSTANT_FALL_CYCLES))
	reset_supervisor_chk_i (.REF_CLK(REF_CLK), .RST(RST), .SUPPLY_LOW(SUPPLY_LOW),
	.AUX_LOW(AUX_LOW), .LONG_PRESS_IN_A_N(LONG_PRESS_IN_A_N),
	.LONG_PRESS_IN_B_OR_INSTANT_IN(LONG_PRESS_IN_B_OR_INSTANT_IN), .RESET_OUT_N(RESET_OUT_N));

// ---- panel_model.sv ----
// front panel and processor side model for the reset supervisor
`timescale 1ns/10ps
module panel_model (
	// clock and bench commands
	input wire logic clk,
	input wire logic press,
	input wire logic card,
	// supervisor pins
	input wire logic reset_n,
	output logic button_n,
	output logic card_in,
	// observed reset pulses
	output int pulses,
	output int last_len
);
	int run = 0;
	int bounce = 0;
	assign card_in = card;
	// contacts chatter on release, so the supervisor must filter it
	always @(posedge clk)
	begin
		bounce <= press ? 6 : (bounce > 0 ? bounce - 1 : 0);
		button_n <= !press && (bounce == 0 || bounce[0]);
	end
	// processor reset input: count and time each low pulse
	always @(posedge clk)
	begin
		run <= reset_n ? 0 : run + 1;
		if (reset_n && run > 0)
		begin
			pulses <= pulses + 1;
			last_len <= run;
		end
	end
endmodule : panel_model

// ---- testbench.sv ----
// self-checking bench for the reset supervisor timing
`timescale 1ns/10ps
module testbench;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic supply_low = 1'b0;
	logic aux_low = 1'b0;
	logic press = 1'b0;
	logic card = 1'b0;
	logic btn_b_n = 1'b1;
	logic button_n, card_in, reset_out_n, reset_dual_n;
	int pulses, last_len, p;
	int mismatches = 0;
	int tests_run = 0;
	always #5 ref_clk = ~ref_clk;
	// long counts shortened so the run stays brief
	reset_supervisor #(.VARIANT(reset_supervisor_pkg::VARIANT_INSTANT),
		.HOLD_OPTION(reset_supervisor_pkg::HOLD_OPT_T), .SUPPLY_RECOVERY_CYCLES(200),
		.MANUAL_PULSE_CYCLES(200), .CYCLES_PER_10MS(10), .RELEASE_DEBOUNCE_CYCLES(20),
		.INSTANT_FALL_CYCLES(100)) reset_supervisor_i (.REF_CLK(ref_clk), .RST(rst),
		.SUPPLY_LOW(supply_low), .AUX_LOW(aux_low), .LONG_PRESS_IN_A_N(button_n),
		.LONG_PRESS_IN_B_OR_INSTANT_IN(card_in), .RESET_OUT_N(reset_out_n));
	panel_model panel_model_i (.clk(ref_clk), .press(press), .card(card), .reset_n(reset_out_n),
		.button_n(button_n), .card_in(card_in), .pulses(pulses), .last_len(last_len));
	// dual variant: both long-press inputs must overlap for the whole setup
	reset_supervisor #(.VARIANT(reset_supervisor_pkg::VARIANT_DUAL),
		.HOLD_OPTION(reset_supervisor_pkg::HOLD_OPT_T), .SUPPLY_RECOVERY_CYCLES(200),
		.MANUAL_PULSE_CYCLES(200), .CYCLES_PER_10MS(10), .RELEASE_DEBOUNCE_CYCLES(20),
		.INSTANT_FALL_CYCLES(100)) reset_supervisor_dual_i (.REF_CLK(ref_clk), .RST(rst),
		.SUPPLY_LOW(supply_low), .AUX_LOW(aux_low), .LONG_PRESS_IN_A_N(button_n),
		.LONG_PRESS_IN_B_OR_INSTANT_IN(btn_b_n), .RESET_OUT_N(reset_dual_n));
	task check(input logic [31:0] got, input logic [31:0] want);
		tests_run++;
		if (got !== want)
		begin
			mismatches++;
			$display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, want);
		end
	endtask : check
	task cyc(input int n);
		repeat (n) @(negedge ref_clk);
	endtask : cyc
	task wait_high(input int limit);
		for (int n = 0; n < limit && reset_out_n !== 1'b1; n++)
			@(negedge ref_clk);
		check(reset_out_n, 1'b1);
		// the panel model logs the pulse on the edge after the rise
		cyc(1);
	endtask : wait_high
	task t_undervolt;
		for (int k = 0; k < 2; k++)
		begin
			p = pulses;
			supply_low = (k == 0);
			aux_low = (k == 1);
			cyc(5);
			check(reset_out_n, 1'b0);
			check(reset_dual_n, 1'b0);
			cyc(25);
			supply_low = 1'b0;
			aux_low = 1'b0;
			cyc(195);
			check(reset_out_n, 1'b0);
			wait_high(30);
			check(pulses, p + 1);
		end
	endtask : t_undervolt
	task t_press;
		p = pulses;
		press = 1'b1;
		cyc(1600);
		press = 1'b0;
		cyc(300);
		check(pulses, p);
		press = 1'b1;
		cyc(1700);
		check(reset_out_n, 1'b0);
		check(reset_dual_n, 1'b1);
		cyc(700);
		check(pulses, p + 1);
		check(last_len >= 133 && last_len <= 267, 1'b1);
		press = 1'b0;
		cyc(300);
		check(pulses, p + 1);
	endtask : t_press
	task t_instant;
		p = pulses;
		card = 1'b1;
		cyc(5);
		card = 1'b0;
		cyc(200);
		check(pulses, p);
		card = 1'b1;
		cyc(60);
		check(reset_out_n, 1'b0);
		card = 1'b0;
		cyc(110);
		card = 1'b1;
		wait_high(600);
		check(last_len >= 300, 1'b1);
		card = 1'b0;
	endtask : t_instant
	task t_dual;
		btn_b_n = 1'b0;
		press = 1'b1;
		cyc(800);
		btn_b_n = 1'b1;
		cyc(100);
		btn_b_n = 1'b0;
		cyc(800);
		check(reset_dual_n, 1'b1);
		cyc(200);
		check(reset_dual_n, 1'b1);
		press = 1'b0;
		btn_b_n = 1'b1;
		cyc(100);
		check(reset_dual_n, 1'b1);
		btn_b_n = 1'b0;
		press = 1'b1;
		cyc(1670);
		check(reset_dual_n, 1'b1);
		cyc(30);
		check(reset_dual_n, 1'b0);
		press = 1'b0;
		btn_b_n = 1'b1;
		cyc(300);
		check(reset_dual_n, 1'b1);
	endtask : t_dual
	task wrap_up;
		if (mismatches == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : wrap_up
	initial
	begin
		cyc(5);
		rst = 1'b0;
		wait_high(400);
		check(last_len >= 200 && last_len <= 210, 1'b1);
		t_undervolt();
		t_press();
		t_instant();
		t_dual();
		wrap_up();
	end
	// watchdog far past the expected run
	initial
	begin
		#300000;
		mismatches++;
		wrap_up();
	end
endmodule : testbench
